// File: channel_pin_model.sv
// Pin model: outside drivers on the timer channel pins
`timescale 1ns/1ps
`default_nettype none
module channel_pin_model (
    input  wire logic [5:0] ch_out,
    input  wire logic [5:0] ch_oe,
    input  wire logic [5:0] ext_level,
    output logic      [5:0] ch_in
);
    // A driven pin reads back its own level; a released one follows the outside source
    assign ch_in = (ch_oe & ch_out) | (~ch_oe & ext_level);
endmodule  // channel_pin_model
`default_nettype wire

// File: timer_channel_mode_control.sv
// Timer channel mode control: channel registers, modes, pin logic and APB slave
//
// Behaviour
// - Edge select 00 releases the pin
// - Input capture on rising, falling or both
// - Output compare toggles, clears or sets
// - Edge-aligned PWM, high- or low-true pulses
// - Center select gives center-aligned PWM
// - Combine: high-true sets on n, clears on n+1; low-true the reverse
// - Dual capture, one-shot or continuous
// - Dual capture edges follow edge select
// - Event sets flag; writing one no effect
// - Flag cleared by read then zero write
// - Event between read and write keeps flag
// - Interrupt enable gates channel interrupt request
// - Mode and edge bits need write-protect disable
// - Bits one and zero read zero
// - Channel registers from 5h, stride 3
// - Offset 4h holds modulo low byte
// - Overflow flag set clock after modulo
// - Modulo writes buffered until update strobe
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_control #(
    parameter int CNT_W = timer_channel_pkg::CNT_W
) (
    input  wire logic                                        core_clk,
    input  wire logic                                        arst_n,
    input  wire logic                                        psel,
    input  wire logic                                        penable,
    input  wire logic                                        pwrite,
    input  wire logic [timer_channel_pkg::ADDR_W-1:0]        paddr,
    input  wire logic [31:0]                                 pwdata,
    output logic      [31:0]                                 prdata,
    output logic                                             pready,
    output logic                                             pslverr,
    input  wire logic [CNT_W-1:0]                            cnt_value,
    input  wire logic                                        cnt_tick,
    input  wire logic                                        cnt_up,
    input  wire logic                                        reload_stb,
    input  wire logic [timer_channel_pkg::NUM_CH*CNT_W-1:0]  ch_value,
    input  wire logic [timer_channel_pkg::NUM_CH-1:0]        ch_in,
    output logic      [timer_channel_pkg::NUM_CH-1:0]        ch_out,
    output logic      [timer_channel_pkg::NUM_CH-1:0]        ch_oe,
    output logic      [timer_channel_pkg::NUM_CH-1:0]        cap_stb,
    output logic      [timer_channel_pkg::NUM_CH-1:0]        chan_irq_req,
    output logic      [CNT_W-1:0]                            modulo_value,
    output logic                                             counter_overflow_flag,
    output logic                                             irq
);

    localparam int NCH = timer_channel_pkg::NUM_CH;
    localparam int NPR = timer_channel_pkg::NUM_PAIRS;
    localparam int IRW = timer_channel_pkg::IRQ_W;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [timer_channel_pkg::IDX_W-1:0] ch_index(input int ch);
        ch_index = timer_channel_pkg::IDX_CH_BASE
                 + timer_channel_pkg::IDX_CH_STRIDE * timer_channel_pkg::IDX_W'(ch);
    endfunction

    function automatic logic edge_hit(input logic [1:0] els, input logic rise,
                                      input logic fall);
        edge_hit = (els[0] & rise) | (els[1] & fall);
    endfunction

    function automatic logic mode_legal(input logic dec, input logic comb, input logic cpw,
                                        input logic [1:0] els);
        if (els == timer_channel_pkg::ELS_NONE) begin
            mode_legal = 1'b1;
        end else if (dec) begin
            mode_legal = !comb && !cpw;
        end else begin
            mode_legal = !(comb && cpw);
        end
    endfunction

    function automatic timer_channel_pkg::ch_mode_type mode_of(input logic dec,
            input logic comb, input logic cpw, input logic [1:0] ms, input logic [1:0] els);
        if (els == timer_channel_pkg::ELS_NONE) begin
            mode_of = timer_channel_pkg::MODE_NONE;
        end else if (dec) begin
            mode_of = timer_channel_pkg::MODE_DUAL;
        end else if (comb) begin
            mode_of = timer_channel_pkg::MODE_COMBINE;
        end else if (cpw) begin
            mode_of = timer_channel_pkg::MODE_CPWM;
        end else if (ms == timer_channel_pkg::MS_CAPTURE) begin
            mode_of = timer_channel_pkg::MODE_CAPTURE;
        end else if (ms == timer_channel_pkg::MS_COMPARE) begin
            mode_of = timer_channel_pkg::MODE_COMPARE;
        end else begin
            mode_of = timer_channel_pkg::MODE_EPWM;
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [CNT_W-1:0]    mod_buf_q;
    logic [CNT_W-1:0]    mod_act_q;
    logic [7:0]          ctrl_q;
    logic [IRW-1:0]      ists_q;
    logic [IRW-1:0]      imask_q;
    logic [NCH-1:0]      flag_q;
    logic [NCH-1:0]      ie_q;
    logic [NCH-1:0]      armed_q;
    logic [1:0]          ms_q [NCH];
    logic [1:0]          els_q [NCH];
    timer_channel_pkg::ch_mode_type mode_q [NCH];
    timer_channel_pkg::dual_state_type dual_q [NPR];
    logic [NCH-1:0]      in_prev_q;
    logic [NCH-1:0]      out_q;
    logic [NCH-1:0]      cap_q;
    logic [31:0]         prdata_q;
    logic                slverr_q;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire [timer_channel_pkg::IDX_W-1:0] idx = paddr[timer_channel_pkg::ADDR_W-1:2];
    wire word_ok   = (paddr[1:0] == 2'h0);
    wire hit_modh  = word_ok && (idx == timer_channel_pkg::IDX_MOD_HIGH);
    wire hit_modl  = word_ok && (idx == timer_channel_pkg::IDX_MOD_LOW);
    wire hit_ctrl  = word_ok && (idx == timer_channel_pkg::IDX_CTRL);
    wire hit_ists  = word_ok && (idx == timer_channel_pkg::IDX_IRQ_STATUS);
    wire hit_imask = word_ok && (idx == timer_channel_pkg::IDX_IRQ_MASK);
    logic [NCH-1:0] ch_hit;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_hit[i] = word_ok && (idx == ch_index(i));
        end
    end
    wire mapped  = hit_modh | hit_modl | hit_ctrl | hit_ists | hit_imask | (|ch_hit);
    wire setup   = psel & ~penable;
    wire access  = psel & penable;
    wire wr_en   = access & pwrite & mapped;
    wire rd_done = setup & ~pwrite & mapped;  // Same edge that latches prdata
    wire [7:0] wbyte = pwdata[7:0];
    wire wp_off  = ctrl_q[timer_channel_pkg::CTRL_WRITE_PROTECT_DISABLE];
    wire center_aligned_select   = ctrl_q[timer_channel_pkg::CTRL_CENTER_ALIGNED_SELECT];

    assign pready  = access;
    assign prdata  = prdata_q;
    assign pslverr = slverr_q & access;

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (hit_modh) rd_byte = mod_buf_q[15:8];
        if (hit_modl) rd_byte = mod_buf_q[7:0];
        if (hit_ctrl) rd_byte = ctrl_q;
        if (hit_ists) rd_byte = {1'b0, ists_q};
        if (hit_imask) rd_byte = {1'b0, imask_q};
        for (int i = 0; i < NCH; i++) begin
            if (ch_hit[i]) begin
                rd_byte = {flag_q[i], ie_q[i], ms_q[i], els_q[i],
                           timer_channel_pkg::CSC_RSVD};
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter compare and pin edges
    // ------------------------------------------------------------------
    wire period_end = cnt_tick && (cnt_value == mod_act_q);
    logic [NCH-1:0] match;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] fall;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            match[i] = cnt_tick && (cnt_value == ch_value[i*CNT_W +: CNT_W]);
            rise[i]  = ch_in[i] & ~in_prev_q[i];
            fall[i]  = ~ch_in[i] & in_prev_q[i];
        end
    end

    // ------------------------------------------------------------------
    // Mode decode; an illegal mix keeps the last legal mode
    // ------------------------------------------------------------------
    timer_channel_pkg::ch_mode_type mode_d [NCH];
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            automatic logic dec  = ctrl_q[timer_channel_pkg::CTRL_DECAP_LSB + i/2];
            automatic logic comb = ctrl_q[timer_channel_pkg::CTRL_COMBINE_LSB + i/2];
            if (mode_legal(dec, comb, center_aligned_select, els_q[i])) begin
                mode_d[i] = mode_of(dec, comb, center_aligned_select, ms_q[i], els_q[i]);
            end else begin
                mode_d[i] = mode_q[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel behaviour: events, captures and pin levels
    // ------------------------------------------------------------------
    logic [NCH-1:0] ev;
    logic [NCH-1:0] cap_d;
    logic [NCH-1:0] out_d;
    logic [NCH-1:0] oe_w;
    timer_channel_pkg::dual_state_type dual_d [NPR];
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            automatic logic low_true = els_q[i][0];
            ev[i]    = 1'b0;
            cap_d[i] = 1'b0;
            out_d[i] = out_q[i];
            oe_w[i]  = 1'b0;
            unique case (mode_q[i])
                timer_channel_pkg::MODE_NONE: begin
                    out_d[i] = 1'b0;
                end
                timer_channel_pkg::MODE_CAPTURE: begin
                    ev[i]    = edge_hit(els_q[i], rise[i], fall[i]);
                    cap_d[i] = ev[i];
                end
                timer_channel_pkg::MODE_COMPARE: begin
                    oe_w[i] = 1'b1;
                    ev[i]   = match[i];
                    if (match[i]) begin
                        unique case (els_q[i])
                            timer_channel_pkg::ELS_RISE: out_d[i] = ~out_q[i];
                            timer_channel_pkg::ELS_FALL: out_d[i] = 1'b0;
                            timer_channel_pkg::ELS_BOTH: out_d[i] = 1'b1;
                            default:                     out_d[i] = out_q[i];
                        endcase
                    end
                end
                timer_channel_pkg::MODE_EPWM: begin
                    oe_w[i] = 1'b1;
                    ev[i]   = match[i];
                    if (period_end) out_d[i] = ~low_true;
                    if (match[i]) out_d[i] = low_true;
                end
                timer_channel_pkg::MODE_CPWM: begin
                    oe_w[i] = 1'b1;
                    ev[i]   = match[i];
                    if (match[i] && cnt_up) out_d[i] = low_true;
                    if (match[i] && !cnt_up) out_d[i] = ~low_true;
                end
                timer_channel_pkg::MODE_COMBINE: begin
                    // Only the even pin of a pair drives; the odd pin stays free
                    ev[i] = match[i];
                    if (i % 2 == 0) begin
                        oe_w[i] = 1'b1;
                        if (match[i]) out_d[i] = ~low_true;
                        if (match[i+1]) out_d[i] = low_true;
                    end
                end
                timer_channel_pkg::MODE_DUAL: begin
                    out_d[i] = 1'b0;
                end
                default: begin
                    out_d[i] = 1'b0;
                end
            endcase
        end
        // Dual-edge capture: both edges are taken on the even pin of the pair
        for (int p = 0; p < NPR; p++) begin
            automatic int n = 2 * p;
            dual_d[p] = dual_q[p];
            if (mode_q[n] != timer_channel_pkg::MODE_DUAL) begin
                dual_d[p] = timer_channel_pkg::DUAL_FIRST;
            end else begin
                unique case (dual_q[p])
                    timer_channel_pkg::DUAL_FIRST: begin
                        if (edge_hit(els_q[n], rise[n], fall[n])) begin
                            ev[n]     = 1'b1;
                            cap_d[n]  = 1'b1;
                            dual_d[p] = timer_channel_pkg::DUAL_SECOND;
                        end
                    end
                    timer_channel_pkg::DUAL_SECOND: begin
                        if (edge_hit(els_q[n+1], rise[n], fall[n])) begin
                            ev[n+1]    = 1'b1;
                            cap_d[n+1] = 1'b1;
                            dual_d[p]  = ms_q[n][0] ? timer_channel_pkg::DUAL_FIRST
                                                    : timer_channel_pkg::DUAL_DONE;
                        end
                    end
                    timer_channel_pkg::DUAL_DONE: begin
                        // One-shot stays idle until software rewrites the channel
                        if (wr_en && ch_hit[n]) dual_d[p] = timer_channel_pkg::DUAL_FIRST;
                    end
                    default: dual_d[p] = timer_channel_pkg::DUAL_FIRST;
                endcase
            end
        end
    end

    assign ch_out       = out_q;
    assign ch_oe        = oe_w;
    assign cap_stb      = cap_q;
    assign chan_irq_req = flag_q & ie_q;
    assign modulo_value = mod_act_q;
    assign counter_overflow_flag = ists_q[timer_channel_pkg::IRQ_OVF_BIT];
    assign irq          = |(ists_q & imask_q);

    // ------------------------------------------------------------------
    // Flag clearing sequence and interrupt status
    // ------------------------------------------------------------------
    logic [NCH-1:0] flag_d;
    logic [NCH-1:0] armed_d;
    logic [NCH-1:0] clr_w;
    logic [IRW-1:0] ists_set;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            clr_w[i]   = wr_en && ch_hit[i] && armed_q[i]
                         && !wbyte[timer_channel_pkg::CSC_FLAG];
            flag_d[i]  = (flag_q[i] & ~clr_w[i]) | ev[i];
            armed_d[i] = armed_q[i];
            if (rd_done && ch_hit[i] && flag_q[i]) armed_d[i] = 1'b1;
            if (wr_en && ch_hit[i]) armed_d[i] = 1'b0;
            if (ev[i]) armed_d[i] = 1'b0;
            ists_set[i] = ev[i] & ie_q[i];
        end
        ists_set[timer_channel_pkg::IRQ_OVF_BIT] = period_end;
    end
    wire [IRW-1:0] ists_clr = (wr_en && hit_ists) ? wbyte[IRW-1:0] : '0;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q    <= '0;
            armed_q   <= '0;
            ists_q    <= '0;
            in_prev_q <= '0;
            out_q     <= '0;
            cap_q     <= '0;
            prdata_q  <= 32'h0000_0000;
            slverr_q  <= 1'b0;
        end else begin
            flag_q    <= flag_d;
            armed_q   <= armed_d;
            ists_q    <= (ists_q & ~ists_clr) | ists_set;
            in_prev_q <= ch_in;
            out_q     <= out_d;
            cap_q     <= cap_d;
            if (setup) begin
                prdata_q <= {24'h00_0000, rd_byte};
                slverr_q <= ~mapped;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mod_buf_q <= timer_channel_pkg::MOD_RESET;
            mod_act_q <= timer_channel_pkg::MOD_RESET;
            ctrl_q    <= timer_channel_pkg::CTRL_RESET;
            imask_q   <= '0;
        end else begin
            if (wr_en && hit_modh) mod_buf_q[15:8] <= wbyte;
            if (wr_en && hit_modl) mod_buf_q[7:0] <= wbyte;
            if (reload_stb) mod_act_q <= mod_buf_q;
            if (wr_en && hit_ctrl) ctrl_q <= wbyte;
            if (wr_en && hit_imask) imask_q <= wbyte[IRW-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                ie_q[i]   <= 1'b0;
                ms_q[i]   <= 2'h0;
                els_q[i]  <= timer_channel_pkg::ELS_NONE;
                mode_q[i] <= timer_channel_pkg::MODE_NONE;
            end
            for (int p = 0; p < NPR; p++) begin
                dual_q[p] <= timer_channel_pkg::DUAL_FIRST;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                mode_q[i] <= mode_d[i];
                if (wr_en && ch_hit[i]) begin
                    ie_q[i] <= wbyte[timer_channel_pkg::CSC_IE];
                    if (wp_off) begin
                        ms_q[i]  <= wbyte[timer_channel_pkg::CSC_MS_HI:
                                          timer_channel_pkg::CSC_MS_LO];
                        els_q[i] <= wbyte[timer_channel_pkg::CSC_ELS_HI:
                                          timer_channel_pkg::CSC_ELS_LO];
                    end
                end
            end
            for (int p = 0; p < NPR; p++) begin
                dual_q[p] <= dual_d[p];
            end
        end
    end

endmodule // timer_channel_mode_control
`default_nettype wire

// File: timer_channel_mode_control_monitor.sv
// Checker: port-level assertions of the timer channel block
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_control_monitor #(
    parameter int CNT_W = 16
) (
    input wire logic             core_clk,
    input wire logic             arst_n,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [CNT_W-1:0] cnt_value,
    input wire logic             cnt_tick,
    input wire logic             reload_stb,
    input wire logic [5:0]       ch_in,
    input wire logic [5:0]       cap_stb,
    input wire logic [CNT_W-1:0] modulo_value,
    input wire logic             counter_overflow_flag
);
    wire logic [9:0] idx = paddr[11:2];
    wire logic       acc = psel && penable;
    wire logic       is_ch = idx >= 10'h005 && idx <= 10'h014
        && (idx - 10'h005) % 10'h003 == 10'h000;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    zero_wait_a: assert property (pready == acc) else $error("pready off access");
    err_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
    ovf_set_a: assert property (cnt_tick && cnt_value == modulo_value |=> counter_overflow_flag)
        else $error("overflow flag not set");
    ovf_sticky_a: assert property (counter_overflow_flag && !(acc && pwrite && idx == 10'h021
        && pwdata[6]) |=> counter_overflow_flag) else $error("overflow flag lost");
    mod_hold_a: assert property (!reload_stb |=> $stable(modulo_value))
        else $error("modulo changed without reload");
    rsvd_zero_a: assert property (acc && !pwrite && is_ch |-> prdata[1:0] == 2'h0)
        else $error("reserved bits not zero");
    ch_map_a: assert property (acc && is_ch |-> !pslverr) else $error("channel reg unmapped");
    mod_low_map_a: assert property (acc && idx == 10'h004 |-> !pslverr)
        else $error("modulo low unmapped");
    cap_edge_a: assert property (cap_stb[2] |-> $past(ch_in[2], 2) != $past(ch_in[2], 3)
        || $past(ch_in[2]) != $past(ch_in[2], 2)) else $error("capture without pin edge");
endmodule  // timer_channel_mode_control_monitor
bind timer_channel_mode_control timer_channel_mode_control_monitor #(.CNT_W(CNT_W)) i_mon (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cnt_value(cnt_value), .cnt_tick(cnt_tick), .reload_stb(reload_stb), .ch_in(ch_in),
    .cap_stb(cap_stb), .modulo_value(modulo_value),
    .counter_overflow_flag(counter_overflow_flag));
`default_nettype wire

// File: timer_channel_mode_control_tb.sv
// Testbench: register, channel and overflow tests of the timer channel block
`timescale 1ns/1ps
`default_nettype none
module timer_channel_mode_control_tb;
    logic        core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic        pready, pslverr, cnt_tick = 1'b0, reload_stb = 1'b0, ovf, irq;
    logic [15:0] cnt_value = 16'h0000, modulo_value;
    logic [95:0] ch_value = 96'h5;
    logic [5:0]  ch_in, ch_out, ch_oe, cap_stb, chan_irq_req, ext_level = 6'h00;
    int          fail_count = 0, samples_checked = 0;
    timer_channel_mode_control #(.CNT_W(16)) i_timer_channel_mode_control (
        .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cnt_value(cnt_value), .cnt_tick(cnt_tick), .cnt_up(1'b0), .reload_stb(reload_stb),
        .ch_value(ch_value), .ch_in(ch_in), .ch_out(ch_out), .ch_oe(ch_oe), .cap_stb(cap_stb),
        .chan_irq_req(chan_irq_req), .modulo_value(modulo_value),
        .counter_overflow_flag(ovf), .irq(irq));
    channel_pin_model i_channel_pin_model (
        .ch_out(ch_out), .ch_oe(ch_oe), .ext_level(ext_level), .ch_in(ch_in));
    initial forever #4 core_clk = ~core_clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Read compares {pslverr, data byte}; a write ignores exp
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [8:0] exp);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        if (!wr) chk({7'h00, pslverr, prdata[7:0]}, {7'h00, exp});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input logic [15:0] v);
        @(posedge core_clk);
        cnt_value <= v;
        cnt_tick <= 1'b1;
        @(posedge core_clk);
        cnt_tick <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        bus(1'b1, 12'h014, 8'hff, 9'h000);
        bus(1'b0, 12'h014, 8'h00, 9'h040);
        bus(1'b0, 12'h004, 8'h00, 9'h100);
        bus(1'b1, 12'h010, 8'h0a, 9'h000);
        bus(1'b0, 12'h010, 8'h00, 9'h00a);
        chk(modulo_value, 16'h0000);
        @(posedge core_clk) reload_stb <= 1'b1;
        @(posedge core_clk) reload_stb <= 1'b0;
        @(posedge core_clk);
        chk(modulo_value, 16'h000a);
        bus(1'b1, 12'h088, 8'h41, 9'h000);
        tick(16'h000a);
        chk(16'({ovf, irq}), 16'h0003);
        bus(1'b1, 12'h084, 8'h40, 9'h000);
        $display("map and modulo test done");
        bus(1'b1, 12'h080, 8'h01, 9'h000);
        bus(1'b1, 12'h014, 8'h54, 9'h000);
        tick(16'h0005);
        chk(16'({ch_oe[0], ch_out[0], chan_irq_req[0], irq}), 16'h000f);
        bus(1'b0, 12'h014, 8'h00, 9'h0d4);
        tick(16'h0005);
        bus(1'b1, 12'h014, 8'h54, 9'h000);
        bus(1'b0, 12'h014, 8'h00, 9'h0d4);
        bus(1'b1, 12'h014, 8'h54, 9'h000);
        bus(1'b0, 12'h014, 8'h00, 9'h054);
        chk(16'(ch_out[0]), 16'h0000);
        bus(1'b1, 12'h014, 8'h14, 9'h000);
        tick(16'h0005);
        chk(16'(chan_irq_req[0]), 16'h0000);
        bus(1'b0, 12'h014, 8'h00, 9'h094);
        bus(1'b1, 12'h014, 8'h10, 9'h000);
        repeat (2) @(posedge core_clk);
        chk(16'(ch_oe[0]), 16'h0000);
        $display("compare and flag test done");
        bus(1'b1, 12'h02c, 8'h44, 9'h000);
        @(posedge core_clk) ext_level <= 6'h04;
        repeat (2) @(posedge core_clk);
        chk(16'(cap_stb), 16'h0004);
        bus(1'b0, 12'h02c, 8'h00, 9'h0c4);
        bus(1'b1, 12'h02c, 8'h44, 9'h000);
        ext_level <= 6'h00;
        repeat (4) @(posedge core_clk);
        bus(1'b0, 12'h02c, 8'h00, 9'h044);
        $display("capture test done");
        print_verdict();
    end
endmodule  // timer_channel_mode_control_tb
`default_nettype wire

// File: timer_channel_pkg.sv
// Package: register map, field layout and mode codes of the timer channel block
`default_nettype none
package timer_channel_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH    = 6;
    localparam int NUM_PAIRS = NUM_CH / 2;
    localparam int CNT_W     = 16;
    localparam int ADDR_W    = 12;
    localparam int IDX_W     = 10;

    // ------------------------------------------------------------------
    // Register indices (byte address = 4 x index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_MOD_HIGH   = 10'h003;
    localparam logic [IDX_W-1:0] IDX_MOD_LOW    = 10'h004;
    localparam logic [IDX_W-1:0] IDX_CH_BASE    = 10'h005;
    localparam logic [IDX_W-1:0] IDX_CH_STRIDE  = 10'h003;
    localparam logic [IDX_W-1:0] IDX_CTRL       = 10'h020;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h021;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h022;

    // ------------------------------------------------------------------
    // Channel status and control fields
    // ------------------------------------------------------------------
    localparam int CSC_FLAG   = 7;
    localparam int CSC_IE     = 6;
    localparam int CSC_MS_HI  = 5;
    localparam int CSC_MS_LO  = 4;
    localparam int CSC_ELS_HI = 3;
    localparam int CSC_ELS_LO = 2;
    localparam logic [1:0] CSC_RSVD = 2'h0;

    // Control register fields
    localparam int CTRL_WRITE_PROTECT_DISABLE       = 0;
    localparam int CTRL_CENTER_ALIGNED_SELECT       = 1;
    localparam int CTRL_COMBINE_LSB = 2;
    localparam int CTRL_DECAP_LSB   = 5;

    // Interrupt status bit of the counter overflow event
    localparam int IRQ_OVF_BIT = 6;
    localparam int IRQ_W       = 7;

    // ------------------------------------------------------------------
    // Selection codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] ELS_NONE    = 2'h0;
    localparam logic [1:0] ELS_RISE    = 2'h1;
    localparam logic [1:0] ELS_FALL    = 2'h2;
    localparam logic [1:0] ELS_BOTH    = 2'h3;
    localparam logic [1:0] MS_CAPTURE  = 2'h0;
    localparam logic [1:0] MS_COMPARE  = 2'h1;
    localparam logic [CNT_W-1:0] MOD_RESET = 16'h0000;
    localparam logic [7:0]       CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Channel modes and dual-edge capture sequence
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        MODE_NONE    = 7'h01,
        MODE_CAPTURE = 7'h02,
        MODE_COMPARE = 7'h04,
        MODE_EPWM    = 7'h08,
        MODE_CPWM    = 7'h10,
        MODE_COMBINE = 7'h20,
        MODE_DUAL    = 7'h40
    } ch_mode_type;

    typedef enum logic [2:0] {
        DUAL_FIRST  = 3'h1,
        DUAL_SECOND = 3'h2,
        DUAL_DONE   = 3'h4
    } dual_state_type;

endpackage
`default_nettype wire
